// ### design/pwd_map.svh
/*
 * address map, passwords, field positions, reset values and timing counts
 * of the password protected watchdog timer.
 * assumes: included by bare name; definitions only.
 */
`ifndef PWD_MAP_SVH
`define PWD_MAP_SVH

// read addresses, low 16 bits of the cpu address
`define PWD_ADDR_CTRL       16'hffa8
`define PWD_ADDR_CNT        16'hffa9
`define PWD_ADDR_RST        16'hffab
// word write addresses
`define PWD_ADDR_CTRL_WR    16'hffa8
`define PWD_ADDR_RST_WR     16'hffaa

// passwords carried in the upper byte of a word write
`define PWD_PASS_CNT        8'h5a
`define PWD_PASS_CTRL       8'ha5
`define PWD_PASS_RST_CLR    8'ha5
`define PWD_PASS_RST_OE     8'h5a
`define PWD_RST_CLR_DATA    8'h00

// field positions
`define PWD_BIT_OVF         7
`define PWD_BIT_WT          6
`define PWD_BIT_TME         5
`define PWD_BIT_WATCHDOG_RESET_FLAG        7
`define PWD_BIT_RESET_OUTPUT_ENABLE       6

// reset values and fixed read bits
`define PWD_CTRL_RESET      8'h18
`define PWD_CNT_RESET       8'h00
`define PWD_RST_RESET       8'h3f
`define PWD_CTRL_FIXED      2'b11
`define PWD_RST_FIXED       6'h3f

// reset pulse lengths in states, one state being one clk_sys period (10 ns)
`define PWD_CLK_NS          10
`define PWD_INT_RST_STATES  518
`define PWD_EXT_RST_STATES  132
`define PWD_INT_RST_CYC     (`PWD_INT_RST_STATES)
`define PWD_EXT_RST_CYC     (`PWD_EXT_RST_STATES)

`endif

// ### design/pwd_pkg.sv
/*
 * types of the password protected watchdog timer.
 * assumes: compiled before every module of the block.
 */
package pwd_pkg;

    // register state of the core
    typedef struct packed {
        logic       ovf;
        logic       wt;
        logic       timer_run_enable;
        logic [2:0] cks;
        logic [7:0] cnt;
        logic       watchdog_reset_flag;
        logic       reset_output_enable;
        logic       ovf_armed;
        logic       watchdog_reset_flag_armed;
        logic [7:0] rdata;
    } pwd_core_t;

    // state of the reset pulse generator
    typedef struct packed {
        logic [9:0] cnt;
        logic       int_rst;
        logic       ext_rst;
    } pwd_pulse_t;

    // state of the prescaler
    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } pwd_presc_t;

endpackage

// ### design/pwd_prescaler.sv
/*
 * free running prescaler: one-cycle tick at clk_sys divided by
 * 2, 32, 64, 128, 256, 512, 2048 or 4096 as the 3-bit select picks.
 * assumes: single clk_sys domain, select changed only while the counter is halted.
 */
`timescale 1ns/1ps
module pwd_prescaler (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // divider select and tick
    input  wire logic [2:0] cks,
    output logic            tick
);
    import pwd_pkg::*;

    pwd_presc_t s_reg;
    pwd_presc_t s_next;

    // low mask of the divider: tick when all masked bits are ones
    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    div_mask = 12'h001;
            3'h1:    div_mask = 12'h01f;
            3'h2:    div_mask = 12'h03f;
            3'h3:    div_mask = 12'h07f;
            3'h4:    div_mask = 12'h0ff;
            3'h5:    div_mask = 12'h1ff;
            3'h6:    div_mask = 12'h7ff;
            default: div_mask = 12'hfff;
        endcase
    endfunction

    // counter never stops, so a running timer sees evenly spaced ticks
    always_comb begin
        s_next      = s_reg;
        s_next.cnt  = s_reg.cnt + 12'h001;
        s_next.tick = ((s_reg.cnt & div_mask(cks)) == div_mask(cks)); // [RULE_07]
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule

// ### design/pwd_reset_pulse.sv
/*
 * reset pulse generator: on a fire pulse holds the internal chip reset
 * for a fixed number of states and, if enabled, the external reset for fewer.
 * assumes: single clk_sys domain; fire is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "pwd_map.svh"
module pwd_reset_pulse #(
    parameter int INT_CYC = `PWD_INT_RST_CYC,
    parameter int EXT_CYC = `PWD_EXT_RST_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // trigger
    input  wire logic fire,
    input  wire logic ext_en,
    // pulses, high while active
    output logic      int_rst,
    output logic      ext_rst
);
    import pwd_pkg::*;

    localparam logic [9:0] INT_LAST = 10'(INT_CYC - 1);
    localparam logic [9:0] EXT_LAST = 10'(INT_CYC - EXT_CYC);

    pwd_pulse_t s_reg;
    pwd_pulse_t s_next;

    // count down from the start; a new fire during a pulse is ignored
    always_comb begin
        s_next = s_reg;
        if (s_reg.int_rst) begin
            s_next.cnt     = s_reg.cnt - 10'h001;
            s_next.int_rst = (s_reg.cnt != 10'h000);            // [RULE_19]
            s_next.ext_rst = s_reg.ext_rst && (s_reg.cnt != EXT_LAST);
        end else if (fire) begin
            s_next.cnt     = INT_LAST;
            s_next.int_rst = 1'b1;                              // [RULE_19]
            s_next.ext_rst = ext_en;                            // [RULE_12]
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign int_rst = s_reg.int_rst;
    assign ext_rst = s_reg.ext_rst;
endmodule

// ### design/pwd_watchdog.sv
/*
 * password protected 8-bit watchdog / interval timer with its three
 * registers on the internal cpu bus, reset pulse generation and the
 * open-drain external reset output.
 * assumes: bus signals and standby come from logic on clk_sys; rstn is the
 * external reset pin, already synchronised in its release by the chip.
 */
// What this block does
// RULE_01 - 8-bit counter counts selected prescaler ticks while run enable is set
// RULE_02 - counter wrap from ff to 00 sets the overflow flag
// RULE_03 - counter is zero after any reset and while run enable is 0
// RULE_04 - overflow flag clears only by read-as-1 then write 0; writing 1 ignored
// RULE_05 - mode bit: 0 interval interrupt, 1 chip reset on overflow; resets 0
// RULE_06 - run enable 1 counts and enables interrupt; 0 holds zero; resets 0
// RULE_07 - 3-bit select picks clock divided by 2 up to 4096; resets 000
// RULE_08 - control bits 7..5 clear in reset and standby; bits 2..0 keep in standby
// RULE_09 - control bits 4 and 3 read as 1 always
// RULE_10 - reset status bits 7 and 6 initialised only by the reset pin
// RULE_11 - reset flag sets on watchdog reset; clears by pin or read-1 then write-0
// RULE_12 - reset output enable drives watchdog reset low on the pin; resets 0
// RULE_13 - reset status bits 5..0 fixed, read as 1
// RULE_14 - counter and control take only word writes with 5a or a5 password
// RULE_15 - counter and control share one write address, password selects target
// RULE_16 - reset status word writes: a5/00 clears flag, 5a loads output enable
// RULE_17 - byte readable at ffa8 control, ffa9 counter, ffab reset status
// RULE_18 - software clears standby before enabling watchdog; clears enable on standby
// RULE_19 - watchdog reset holds chip 518 states, external output 132 states
// RULE_20 - internal watchdog reset clears overflow flag but keeps reset flag
// RULE_21 - counter write in the same cycle as a tick wins, increment lost
// RULE_22 - interval interrupt requested whenever overflow flag is 1 in interval mode; the code also requires run enable to be 1
// RULE_23 - word writes with unknown password change no register
`timescale 1ns/1ps
`include "pwd_map.svh"
module pwd_watchdog #(
    parameter int INT_CYC = `PWD_INT_RST_CYC,
    parameter int EXT_CYC = `PWD_EXT_RST_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // cpu bus, low 16 address bits
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd_en,
    input  wire logic        bus_wr_en,
    input  wire logic        bus_word,
    input  wire logic [15:0] bus_wdata,
    output logic [7:0]       bus_rdata,
    // system state
    input  wire logic        software_standby_bit,
    // events and resets
    output logic             interval_overflow_interrupt,
    output logic             chip_reset_n,
    output logic             external_reset_out_pin_o,
    output logic             external_reset_out_pin_oe
);
    import pwd_pkg::*;

    pwd_core_t s_reg;
    pwd_core_t s_next;

    logic tick;
    logic int_rst;
    logic ext_rst;
    logic fire;

    logic [7:0] ctrl_view;
    logic [7:0] rst_view;
    logic       wr_word;
    logic       wr_ctrl_addr;
    logic       wr_rst_addr;
    logic [7:0] wr_pass;
    logic [7:0] wr_data;
    logic       cnt_load;
    logic       ctrl_load;
    logic       overflow;

    // prescaler chosen by the clock select field
    pwd_prescaler u_presc (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cks     (s_reg.cks),
        .tick    (tick)
    );

    // reset pulses after a watchdog overflow
    pwd_reset_pulse #(
        .INT_CYC (INT_CYC),
        .EXT_CYC (EXT_CYC)
    ) u_pulse (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .fire    (fire),
        .ext_en  (s_reg.reset_output_enable),
        .int_rst (int_rst),
        .ext_rst (ext_rst)
    );

    // read views with fixed ones in the reserved fields
    always_comb begin
        ctrl_view = {s_reg.ovf, s_reg.wt, s_reg.timer_run_enable, `PWD_CTRL_FIXED, s_reg.cks};  // [RULE_09]
        rst_view  = {s_reg.watchdog_reset_flag, s_reg.reset_output_enable, `PWD_RST_FIXED};                    // [RULE_13]
    end

    // word write decode; byte writes never reach a register
    always_comb begin
        wr_word      = bus_wr_en && bus_word && !int_rst;                       // [RULE_14]
        wr_pass      = bus_wdata[15:8];
        wr_data      = bus_wdata[7:0];
        wr_ctrl_addr = wr_word && (bus_addr == `PWD_ADDR_CTRL_WR);              // [RULE_15]
        wr_rst_addr  = wr_word && (bus_addr == `PWD_ADDR_RST_WR);
        cnt_load     = wr_ctrl_addr && (wr_pass == `PWD_PASS_CNT);              // [RULE_14] [RULE_23]
        ctrl_load    = wr_ctrl_addr && (wr_pass == `PWD_PASS_CTRL);             // [RULE_14] [RULE_23]
    end

    // wrap of the counter on a tick that a write does not override
    always_comb begin
        overflow = tick && s_reg.timer_run_enable && !cnt_load && (s_reg.cnt == 8'hff) && !int_rst;  // [RULE_02]
        fire     = overflow && s_reg.wt;                                                // [RULE_05]
    end

    // register update; bus and standby clears are applied before the sets so a set wins
    always_comb begin
        s_next = s_reg;

        // bus reads: byte reads of the three registers
        if (bus_rd_en) begin
            if (bus_addr == `PWD_ADDR_CTRL) begin                               // [RULE_17]
                s_next.rdata = ctrl_view;
                if (s_reg.ovf) begin
                    s_next.ovf_armed = 1'b1;                                    // [RULE_04]
                end
            end else if (bus_addr == `PWD_ADDR_CNT) begin                       // [RULE_17]
                s_next.rdata = s_reg.cnt;
            end else if (bus_addr == `PWD_ADDR_RST) begin                       // [RULE_17]
                s_next.rdata = rst_view;
                if (s_reg.watchdog_reset_flag) begin
                    s_next.watchdog_reset_flag_armed = 1'b1;                                   // [RULE_11]
                end
            end else begin
                s_next.rdata = 8'h00;
            end
        end

        // counter: count, then a write wins over the same-cycle tick
        if (tick && s_reg.timer_run_enable) begin
            s_next.cnt = s_reg.cnt + 8'h01;                                     // [RULE_01]
        end
        if (cnt_load) begin
            s_next.cnt = wr_data;                                               // [RULE_21]
        end

        // control write; the flag bit only accepts a 0 after an armed read
        if (ctrl_load) begin
            s_next.wt  = wr_data[`PWD_BIT_WT];                                  // [RULE_05]
            s_next.timer_run_enable = wr_data[`PWD_BIT_TME];                                 // [RULE_06]
            s_next.cks = wr_data[2:0];                                          // [RULE_07]
            if (!wr_data[`PWD_BIT_OVF] && s_reg.ovf_armed) begin
                s_next.ovf = 1'b0;                                              // [RULE_04]
            end
            s_next.ovf_armed = 1'b0;
        end

        // reset status write: clear flag or load the output enable
        if (wr_rst_addr) begin
            if (wr_pass == `PWD_PASS_RST_CLR && wr_data == `PWD_RST_CLR_DATA && s_reg.watchdog_reset_flag_armed) begin
                s_next.watchdog_reset_flag = 1'b0;                                             // [RULE_16]
            end else if (wr_pass == `PWD_PASS_RST_OE) begin
                s_next.reset_output_enable = wr_data[`PWD_BIT_RESET_OUTPUT_ENABLE];                         // [RULE_16]
            end
            s_next.watchdog_reset_flag_armed = 1'b0;
        end

        // standby clears bits 7..5 but keeps the clock select
        if (software_standby_bit) begin
            s_next.ovf = 1'b0;                                                  // [RULE_08]
            s_next.wt  = 1'b0;
            s_next.timer_run_enable = 1'b0;
        end

        // halted counter sits at zero
        if (!s_next.timer_run_enable) begin
            s_next.cnt = `PWD_CNT_RESET;                                        // [RULE_03]
        end

        // overflow sets come last so an event beats a same-cycle clear
        if (overflow) begin
            s_next.ovf = 1'b1;                                                  // [RULE_02]
        end
        if (fire) begin
            s_next.watchdog_reset_flag = 1'b1;                                                 // [RULE_11]
        end
        if (!s_next.ovf) begin
            s_next.ovf_armed = 1'b0;
        end
        if (!s_next.watchdog_reset_flag) begin
            s_next.watchdog_reset_flag_armed = 1'b0;
        end

        // internal watchdog reset: control and counter back to reset values,
        // reset flag and output enable survive so software can see the cause
        if (int_rst) begin
            s_next.ovf       = 1'b0;                                            // [RULE_20]
            s_next.wt        = 1'b0;
            s_next.timer_run_enable       = 1'b0;
            s_next.cks       = 3'h0;
            s_next.cnt       = `PWD_CNT_RESET;                                  // [RULE_03]
            s_next.ovf_armed = 1'b0;
        end
    end

    // the pin reset restores everything, including reset status bits 7 and 6
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_reg            <= '0;                                             // [RULE_10]
        end else begin
            s_reg            <= s_next;
        end
    end

    // interval request is a level, gone as soon as the flag is cleared
    assign interval_overflow_interrupt = s_reg.ovf && !s_reg.wt && s_reg.timer_run_enable;   // [RULE_22]
    assign bus_rdata                   = s_reg.rdata;
    assign chip_reset_n                = !int_rst;                              // [RULE_19]
    // open drain: only ever pulls low, released otherwise
    assign external_reset_out_pin_o    = 1'b0;
    assign external_reset_out_pin_oe   = ext_rst;                               // [RULE_12]
endmodule

// ### testbench/pwd_cpu_model.sv
/*
 * cpu software side of the watchdog register bus.
 * assumes: tb calls the tasks; the timer samples on rising edges.
 */
`timescale 1ns/1ps
module pwd_cpu_model (
    // clock
    input  wire logic        clk_sys,
    // bus toward the timer
    output logic [15:0]      bus_addr,
    output logic             bus_rd_en,
    output logic             bus_wr_en,
    output logic             bus_word,
    output logic [15:0]      bus_wdata,
    input  wire logic [7:0]  bus_rdata,
    // system state
    output logic             software_standby_bit
);
    // idle bus from time zero
    initial begin
        bus_addr = 16'h0000;
        bus_rd_en = 1'b0;
        bus_wr_en = 1'b0;
        bus_word = 1'b0;
        bus_wdata = 16'h0000;
        software_standby_bit = 1'b0;
    end

    // password in the upper byte; byte writes only to see them dropped
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_word = w;
        bus_wr_en = 1'b1;
        @(negedge clk_sys);
        bus_wr_en = 1'b0;
        bus_wdata = ~d; // stale data must not look valid
    endtask

    // data taken one cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        @(negedge clk_sys);
        bus_addr = a;
        bus_rd_en = 1'b1;
        @(negedge clk_sys);
        bus_rd_en = 1'b0;
        q = bus_rdata;
    endtask

    // standby entered only in interval mode, never with the watchdog armed
    task automatic standby();
        @(negedge clk_sys);
        software_standby_bit = 1'b1;
        @(negedge clk_sys);
        software_standby_bit = 1'b0;
    endtask
endmodule

// ### testbench/pwd_watchdog_sva.sv
/*
 * port checker of the password protected watchdog timer.
 * assumes: bound to pwd_watchdog; pulse counts handed on from the instance.
 */
`timescale 1ns/1ps
module pwd_watchdog_chk #(
    parameter int INT_CYC = 518,
    parameter int EXT_CYC = 132
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // cpu bus
    input wire logic [15:0] bus_addr,
    input wire logic        bus_rd_en,
    input wire logic        bus_wr_en,
    input wire logic        bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        software_standby_bit,
    // events and resets
    input wire logic        interval_overflow_interrupt,
    input wire logic        chip_reset_n,
    input wire logic        external_reset_out_pin_o,
    input wire logic        external_reset_out_pin_oe
);
    logic [9:0] lo_cnt;
    logic [9:0] oe_cnt;

    // length of the running reset phases; 10 bits cover 518 states
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lo_cnt <= 10'h000;
            oe_cnt <= 10'h000;
        end else begin
            lo_cnt <= chip_reset_n ? 10'h000 : lo_cnt + 10'h001;
            oe_cnt <= external_reset_out_pin_oe ? oe_cnt + 10'h001 : 10'h000;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // bus reads and the start of a watchdog reset
    sequence rd_ctrl_s; bus_rd_en && bus_addr == 16'hffa8; endsequence
    sequence rd_rst_s; bus_rd_en && bus_addr == 16'hffab; endsequence
    sequence rd_hole_s; bus_rd_en && !(bus_addr inside {16'hffa8, 16'hffa9, 16'hffab}); endsequence
    sequence wd_fire_s; $fell(chip_reset_n); endsequence

    ctrl_fixed_a: assert property (rd_ctrl_s |=> bus_rdata[4:3] == 2'b11)
        else $error("control fixed bits not 1");
    rst_fixed_a: assert property (rd_rst_s |=> bus_rdata[5:0] == 6'h3f)
        else $error("reset status fixed bits not 1");
    hole_zero_a: assert property (rd_hole_s |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!bus_rd_en |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    int_len_a: assert property ($rose(chip_reset_n) |-> lo_cnt == INT_CYC)
        else $error("internal reset length wrong");
    ext_len_a: assert property ($fell(external_reset_out_pin_oe) |-> oe_cnt == EXT_CYC)
        else $error("external reset length wrong");
    wd_hold_a: assert property (wd_fire_s |-> (!chip_reset_n)[*8])
        else $error("internal reset too short");
    oe_start_a: assert property ($rose(external_reset_out_pin_oe) |-> wd_fire_s)
        else $error("external reset not with internal reset");
    oe_inside_a: assert property (external_reset_out_pin_oe |-> !chip_reset_n && !external_reset_out_pin_o)
        else $error("external reset outside internal reset");
    irq_quiet_a: assert property (!chip_reset_n |-> !interval_overflow_interrupt)
        else $error("interrupt during watchdog reset");
endmodule

bind pwd_watchdog pwd_watchdog_chk #(.INT_CYC(INT_CYC), .EXT_CYC(EXT_CYC)) chk_u (
    .clk_sys(clk_sys), .rstn(rstn), .bus_addr(bus_addr), .bus_rd_en(bus_rd_en),
    .bus_wr_en(bus_wr_en), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .software_standby_bit(software_standby_bit), .interval_overflow_interrupt(interval_overflow_interrupt),
    .chip_reset_n(chip_reset_n), .external_reset_out_pin_o(external_reset_out_pin_o),
    .external_reset_out_pin_oe(external_reset_out_pin_oe));

// ### testbench/tb.sv
/*
 * top bench of the watchdog: register sequences with expected values.
 * assumes: cpu model drives the bus at falling edges; short reset pulses.
 */
`timescale 1ns/1ps
module tb;
    localparam int INT_N = 8;
    localparam int EXT_N = 3;
    logic        clk_sys;
    logic        rstn;
    logic [15:0] bus_addr;
    logic        bus_rd_en;
    logic        bus_wr_en;
    logic        bus_word;
    logic [15:0] bus_wdata;
    logic [7:0]  bus_rdata;
    logic        sby;
    logic        irq;
    logic        chip_reset_n;
    logic        rst_o;
    logic        rst_oe;
    int          num_errors;
    int          cmp_count;
    int          divs [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    int          nlo;
    int          noe;
    logic [7:0]  q;

    pwd_watchdog #(.INT_CYC(INT_N), .EXT_CYC(EXT_N)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .bus_addr(bus_addr), .bus_rd_en(bus_rd_en),
        .bus_wr_en(bus_wr_en), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .software_standby_bit(sby), .interval_overflow_interrupt(irq), .chip_reset_n(chip_reset_n),
        .external_reset_out_pin_o(rst_o), .external_reset_out_pin_oe(rst_oe));
    pwd_cpu_model cpu_u (
        .clk_sys(clk_sys), .bus_addr(bus_addr), .bus_rd_en(bus_rd_en), .bus_wr_en(bus_wr_en),
        .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .software_standby_bit(sby));

    // 100 mhz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        cpu_u.rd(a, v);
        check(nm, v, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // a used-up wait counts as a mismatch and closes the run
    task automatic timeout(input string nm);
        check(nm, 8'h00, 8'h01);
        end_of_test();
    endtask
    // arm the watchdog at the fastest divider and measure both reset phases
    task automatic wd(input logic oe_en);
        nlo = 0;
        noe = 0;
        cpu_u.wr(16'hffaa, {8'h5a, 1'b0, oe_en, 6'h00}, 1'b1);
        cpu_u.wr(16'hffa8, 16'ha560, 1'b1);
        cpu_u.wr(16'hffa8, 16'h5aff, 1'b1);
        for (int i = 0; chip_reset_n === 1'b1; i++) begin
            if (i > 50) timeout("fire");
            @(negedge clk_sys);
        end
        while (chip_reset_n !== 1'b1 && nlo < 1000) begin
            nlo++;
            noe += int'(rst_oe);
            @(negedge clk_sys);
        end
    endtask

    initial begin
        rstn = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        rchk("ctrl", 16'hffa8, 8'h18);
        rchk("cnt", 16'hffa9, 8'h00);
        rchk("rst", 16'hffab, 8'h3f);
        rchk("hole", 16'hffaa, 8'h00);
        $display("test reset done");
        cpu_u.wr(16'hffa8, 16'ha563, 1'b0);
        cpu_u.wr(16'hffa8, 16'h3c63, 1'b1);
        cpu_u.wr(16'hffaa, 16'h3c40, 1'b1);
        rchk("ctrl", 16'hffa8, 8'h18);
        rchk("rst", 16'hffab, 8'h3f);
        cpu_u.wr(16'hffa8, 16'ha527, 1'b1);
        cpu_u.wr(16'hffa8, 16'h5a10, 1'b1);
        rchk("ctrl", 16'hffa8, 8'h3f);
        cpu_u.rd(16'hffa9, q);
        check("cnt", {7'h00, q inside {8'h10, 8'h11}}, 8'h01);
        cpu_u.wr(16'hffa8, 16'ha507, 1'b1);
        rchk("cnt", 16'hffa9, 8'h00);
        $display("test password done");
        // each divider: overflow, then count ticks over four periods
        for (int c = 0; c < 8; c++) begin
            cpu_u.rd(16'hffa8, q);
            cpu_u.wr(16'hffa8, {8'ha5, 5'h04, c[2:0]}, 1'b1);
            check("irq", {7'h00, irq}, 8'h00);
            cpu_u.wr(16'hffa8, 16'h5aff, 1'b1);
            for (int i = 0; irq !== 1'b1; i++) begin
                if (i > 9000) timeout("irq");
                @(negedge clk_sys);
            end
            check("irq", {7'h00, irq}, 8'h01);
            repeat (4 * divs[c]) @(negedge clk_sys);
            cpu_u.rd(16'hffa9, q);
            check("tick", {7'h00, q inside {[8'h03:8'h06]}}, 8'h01);
            cpu_u.wr(16'hffa8, 16'ha500, 1'b1); // halt before the select changes
        end
        $display("test divider done");
        cpu_u.wr(16'hffa8, 16'ha527, 1'b1);
        rchk("ovf", 16'hffa8, 8'hbf);
        check("irq", {7'h00, irq}, 8'h01);
        cpu_u.wr(16'hffa8, 16'ha5a7, 1'b1);
        rchk("ovf", 16'hffa8, 8'hbf);
        cpu_u.wr(16'hffa8, 16'ha527, 1'b1);
        rchk("ovf", 16'hffa8, 8'h3f);
        check("irq", {7'h00, irq}, 8'h00);
        cpu_u.wr(16'hffa8, 16'ha525, 1'b1);
        cpu_u.standby();
        rchk("sby", 16'hffa8, 8'h1d);
        $display("test flag done");
        wd(1'b0);
        check("lo", 8'(nlo), 8'(INT_N));
        check("oe", 8'(noe), 8'h00);
        rchk("ctrl", 16'hffa8, 8'h18);
        rchk("cnt", 16'hffa9, 8'h00);
        rchk("rst", 16'hffab, 8'hbf);
        @(negedge clk_sys);
        rstn = 1'b0;
        @(negedge clk_sys);
        rstn = 1'b1;
        rchk("rst", 16'hffab, 8'h3f);
        wd(1'b1);
        check("lo", 8'(nlo), 8'(INT_N));
        check("oe", 8'(noe), 8'(EXT_N));
        check("pin", {7'h00, rst_o}, 8'h00);
        rchk("rst", 16'hffab, 8'hff);
        cpu_u.wr(16'hffaa, 16'ha500, 1'b1);
        rchk("rst", 16'hffab, 8'h7f);
        $display("test watchdog done");
        end_of_test();
    end
endmodule
